// ---- serial_unit_a.sv ----
// top of the three-wire serial unit: control, buffer ram and run sequencing
// assumes control bits are held by software; transfer clock unrelated to clk_sys
`timescale 1ns/1ps
`default_nettype none
module serial_unit_a
    import serial_unit_a_pkg::*;
(
    // clocks and reset
    input wire logic clk_sys,
    input wire logic clkLink,
    input wire logic resetn,
    // mode control bits
    input wire logic unitEnable,
    input wire logic autoTransferEnable,
    input wire logic repeatMode,
    input wire logic receiveEnable,
    input wire logic transmitEnable,
    input wire logic bitOrderSelect,
    input wire logic [DIV_W-1:0] clockDivisor,
    input wire logic [IDX_W-1:0] lastIndex,
    input wire logic [GAP_W-1:0] interval,
    // triggers
    input wire logic autoStart,
    input wire logic autoStop,
    // shift data access
    input wire logic shiftDataWrite,
    input wire logic [BYTE_W-1:0] shiftDataIn,
    output logic [BYTE_W-1:0] shiftDataOut,
    // buffer ram access
    input wire logic bufWrite,
    input wire logic bufRead,
    input wire logic [IDX_W-1:0] bufAddr,
    input wire logic [BYTE_W-1:0] bufWriteData,
    output logic [BYTE_W-1:0] bufReadData,
    // status
    output logic transferActive,
    output logic [IDX_W-1:0] byteIndex,
    output logic transferDoneIrq,
    // pins
    output logic serialClockPin,
    output logic serialOutPin,
    input wire logic serialInPin
);
    sys_state_t state_r;
    logic [BYTE_W-1:0] buf_r [BUF_DEPTH];
    logic [BYTE_W-1:0] bufRd_r;
    logic [BYTE_W-1:0] shiftData_r;
    logic [BYTE_W-1:0] txByte_r;
    logic [DIV_W-1:0] divHold_r;
    logic [GAP_W-1:0] gapHold_r;
    logic [IDX_W-1:0] index_r;
    logic [SYNC_W-1:0] doneSync_r;
    logic doneFilt_r;
    logic startTgl_r;
    logic active_r;
    logic autoRun_r;
    logic stopPend_r;
    logic irq_r;
    logic doneTgl;
    logic [BYTE_W-1:0] rxByte;

    // done toggle from the link domain, counted once stages two and three agree
    wire doneStable = doneSync_r[1] == doneSync_r[2];
    wire doneEvt = doneStable && (doneSync_r[2] != doneFilt_r);
    wire cpuBufAccess = bufWrite || bufRead;
    wire singleStart = shiftDataWrite && unitEnable && !autoTransferEnable && !active_r;
    wire autoGo = autoStart && unitEnable && autoTransferEnable
        && (transmitEnable || receiveEnable) && !active_r;
    wire lastByte = index_r == lastIndex;
    wire [BYTE_W-1:0] rxOriented = orient(rxByte, bitOrderSelect);
    wire [BYTE_W-1:0] bufTxByte = transmitEnable ? orient(buf_r[index_r], bitOrderSelect)
        : BYTE_RST;
    // cpu keeps priority on the buffer; the serial side waits, stretching the gap
    wire fetchGo = (state_r == SYS_FETCH) && !cpuBufAccess;
    wire storeGo = (state_r == SYS_STORE) && !(receiveEnable && cpuBufAccess);
    wire serialBufWe = storeGo && receiveEnable;

    assign shiftDataOut = shiftData_r;
    assign bufReadData = bufRd_r;
    assign transferActive = active_r;
    assign byteIndex = index_r;
    assign transferDoneIrq = irq_r;

    serial_link_engine u_engine (
        .clkLink(clkLink),
        .resetn(resetn),
        .startTgl(startTgl_r),
        .unitEnable(unitEnable),
        .txByte(txByte_r),
        .divisor(divHold_r),
        .gapPeriods(gapHold_r),
        .doneTgl_r(doneTgl),
        .rxByte_r(rxByte),
        .serialClockPin(serialClockPin),
        .serialOutPin(serialOutPin),
        .serialInPin(serialInPin)
    );

    // buffer storage has no reset; contents are undefined until written
    always_ff @(posedge clk_sys)
    begin
        if (bufWrite)
            buf_r[bufAddr] <= bufWriteData;
        else if (serialBufWe)
            buf_r[index_r] <= rxOriented;
        bufRd_r <= buf_r[bufAddr];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            doneSync_r <= '0;
            doneFilt_r <= 1'b0;
        end
        else
        begin
            doneSync_r <= {doneSync_r[1:0], doneTgl};
            if (doneStable)
                doneFilt_r <= doneSync_r[2];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            stopPend_r <= 1'b0;
        else if (autoGo)
            stopPend_r <= 1'b0;
        else if (autoStop && active_r && autoRun_r)
            stopPend_r <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= SYS_IDLE;
            shiftData_r <= BYTE_RST;
            txByte_r <= BYTE_RST;
            divHold_r <= '0;
            gapHold_r <= '0;
            index_r <= IDX_RST;
            startTgl_r <= 1'b0;
            active_r <= 1'b0;
            autoRun_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= 1'b0;
            if (!unitEnable && active_r)
            begin
                // clearing the enable ends the run with no done pulse
                state_r <= SYS_IDLE;
                active_r <= 1'b0;
            end
            else
            begin
                unique case (state_r)
                    SYS_IDLE:
                    begin
                        if (singleStart)
                        begin
                            // repeat bit is not looked at here
                            txByte_r <= orient(shiftDataIn, bitOrderSelect);
                            divHold_r <= clockDivisor;
                            gapHold_r <= interval;
                            startTgl_r <= ~startTgl_r;
                            active_r <= 1'b1;
                            autoRun_r <= 1'b0;
                            state_r <= SYS_RUN;
                        end
                        else if (autoGo)
                        begin
                            index_r <= IDX_RST;
                            active_r <= 1'b1;
                            autoRun_r <= 1'b1;
                            state_r <= SYS_FETCH;
                        end
                    end
                    SYS_FETCH:
                    begin
                        if (fetchGo)
                        begin
                            txByte_r <= bufTxByte;
                            divHold_r <= clockDivisor;
                            gapHold_r <= interval;
                            startTgl_r <= ~startTgl_r;
                            state_r <= SYS_RUN;
                        end
                    end
                    SYS_RUN:
                    begin
                        if (doneEvt && !autoRun_r)
                        begin
                            shiftData_r <= rxOriented;
                            irq_r <= 1'b1;
                            active_r <= 1'b0;
                            state_r <= SYS_IDLE;
                        end
                        else if (doneEvt)
                        begin
                            state_r <= SYS_STORE;
                        end
                    end
                    SYS_STORE:
                    begin
                        if (storeGo)
                        begin
                            if (lastByte && repeatMode)
                            begin
                                index_r <= IDX_RST;
                                state_r <= stopPend_r ? SYS_IDLE : SYS_FETCH;
                                active_r <= !stopPend_r;
                                irq_r <= stopPend_r;
                            end
                            else if (lastByte || stopPend_r)
                            begin
                                // range end or stop after the current byte
                                index_r <= lastByte ? index_r : index_r + IDX_ONE;
                                irq_r <= 1'b1;
                                active_r <= 1'b0;
                                state_r <= SYS_IDLE;
                            end
                            else
                            begin
                                index_r <= index_r + IDX_ONE;
                                state_r <= SYS_FETCH;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule // serial_unit_a
`default_nettype wire

// ---- serial_unit_a_pkg.sv ----
// constants and types for the three-wire serial unit with automatic buffer
// assumes one system clock domain and one transfer clock domain
package serial_unit_a_pkg;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 5;
    localparam int BUF_DEPTH = 32;
    localparam int GAP_W = 6;
    localparam int DIV_W = 8;
    localparam int SYNC_W = 3;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [IDX_W-1:0] IDX_RST = 5'h00;
    localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BIT_ONE = 3'h1;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [GAP_W:0] GAP_ONE = 7'h01;

    typedef enum logic [1:0] {
        SYS_IDLE = 2'b00,
        SYS_FETCH = 2'b01,
        SYS_RUN = 2'b10,
        SYS_STORE = 2'b11
    } sys_state_t;

    typedef enum logic [1:0] {
        LNK_IDLE = 2'b00,
        LNK_SHIFT = 2'b01,
        LNK_GAP = 2'b10
    } link_state_t;

    // bit order swap used on both the write and the read path
    function automatic logic [BYTE_W-1:0] orient(input logic [BYTE_W-1:0] d, input logic lsb);
        logic [BYTE_W-1:0] r;
        r = d;
        if (lsb)
        begin
            for (int i = 0; i < BYTE_W; i++)
            begin
                r[i] = d[BYTE_W-1-i];
            end
        end
        return r;
    endfunction
endpackage

// ---- serial_link_engine.sv ----
// link-side byte engine clocked by the transfer clock
// assumes txByte, divisor and gap stay stable from a start toggle until done
`timescale 1ns/1ps
`default_nettype none
module serial_link_engine
    import serial_unit_a_pkg::*;
(
    // clock and reset
    input wire logic clkLink,
    input wire logic resetn,
    // from system domain
    input wire logic startTgl,
    input wire logic unitEnable,
    input wire logic [BYTE_W-1:0] txByte,
    input wire logic [DIV_W-1:0] divisor,
    input wire logic [GAP_W-1:0] gapPeriods,
    // to system domain
    output logic doneTgl_r,
    output logic [BYTE_W-1:0] rxByte_r,
    // pins
    output logic serialClockPin,
    output logic serialOutPin,
    input wire logic serialInPin
);
    link_state_t state_r;
    logic [SYNC_W-1:0] startSync_r;
    logic [SYNC_W-1:0] enSync_r;
    logic [SYNC_W-1:0] inSync_r;
    logic startFilt_r;
    logic enFilt_r;
    logic inFilt_r;
    logic sck_r;
    logic so_r;
    logic [BYTE_W-1:0] shift_r;
    logic [2:0] bitCnt_r;
    logic [DIV_W-1:0] halfCnt_r;
    logic [GAP_W:0] gapCnt_r;

    // a change counts only once the second and third stage agree
    wire startStable = startSync_r[1] == startSync_r[2];
    wire startEvt = startStable && (startSync_r[2] != startFilt_r);
    wire halfEnd = halfCnt_r == divisor;
    wire gapDone = gapCnt_r == {gapPeriods, 1'b0};

    assign serialClockPin = sck_r;
    assign serialOutPin = so_r;

    always_ff @(posedge clkLink or negedge resetn)
    begin
        if (!resetn)
        begin
            startSync_r <= '0;
            enSync_r <= '0;
            inSync_r <= '0;
            startFilt_r <= 1'b0;
            enFilt_r <= 1'b0;
            inFilt_r <= 1'b0;
        end
        else
        begin
            startSync_r <= {startSync_r[1:0], startTgl};
            enSync_r <= {enSync_r[1:0], unitEnable};
            inSync_r <= {inSync_r[1:0], serialInPin};
            if (startStable)
                startFilt_r <= startSync_r[2];
            if (enSync_r[1] == enSync_r[2])
                enFilt_r <= enSync_r[2];
            if (inSync_r[1] == inSync_r[2])
                inFilt_r <= inSync_r[2];
        end
    end

    always_ff @(posedge clkLink or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= LNK_IDLE;
            sck_r <= 1'b1;
            so_r <= 1'b0;
            shift_r <= BYTE_RST;
            bitCnt_r <= '0;
            halfCnt_r <= '0;
            gapCnt_r <= '0;
            doneTgl_r <= 1'b0;
            rxByte_r <= BYTE_RST;
        end
        else if (!enFilt_r)
        begin
            // enable dropped: abandon the byte quietly, no done event
            state_r <= LNK_IDLE;
            sck_r <= 1'b1;
            so_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                LNK_IDLE:
                begin
                    sck_r <= 1'b1;
                    so_r <= 1'b0;
                    if (startEvt)
                    begin
                        shift_r <= txByte;
                        so_r <= txByte[BYTE_W-1];
                        sck_r <= 1'b0;
                        bitCnt_r <= '0;
                        halfCnt_r <= '0;
                        state_r <= LNK_SHIFT;
                    end
                end
                LNK_SHIFT:
                begin
                    halfCnt_r <= halfCnt_r + DIV_ONE;
                    if (halfEnd)
                    begin
                        halfCnt_r <= '0;
                        if (!sck_r)
                        begin
                            // rising edge latches the sampled input
                            sck_r <= 1'b1;
                            shift_r <= {shift_r[BYTE_W-2:0], inFilt_r};
                            bitCnt_r <= bitCnt_r + BIT_ONE;
                            if (bitCnt_r == LAST_BIT)
                            begin
                                gapCnt_r <= '0;
                                state_r <= LNK_GAP;
                            end
                        end
                        else
                        begin
                            sck_r <= 1'b0;
                            so_r <= shift_r[BYTE_W-1];
                        end
                    end
                end
                LNK_GAP:
                begin
                    halfCnt_r <= halfCnt_r + DIV_ONE;
                    if (halfEnd)
                    begin
                        halfCnt_r <= '0;
                        gapCnt_r <= gapCnt_r + GAP_ONE;
                    end
                    if (gapDone)
                    begin
                        // interval in whole serial clock periods, two half bits each, before done
                        doneTgl_r <= ~doneTgl_r;
                        rxByte_r <= shift_r;
                        so_r <= 1'b0;
                        state_r <= LNK_IDLE;
                    end
                end
                default:
                begin
                    state_r <= LNK_IDLE;
                end
            endcase
        end
    end
endmodule // serial_link_engine
`default_nettype wire

// ---- serial_peer_model.sv ----
// far-side peripheral model: a plain shift register on the three-wire link
// assumes the unit owns the serial clock; it drives data on fall, latches on rise
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model
(
    // reset and pins
    input wire logic resetn,
    input wire logic sck,
    input wire logic sdo,
    output logic sdi,
    // bench side
    input wire logic [7:0] peerTx,
    output logic [7:0] peerRx,
    output var int peerFrames
);
    logic [7:0] shift_r;
    logic [2:0] bitCnt_r;
    logic bit_r;
    // between frames the line shows the inverse of its last bit, never a held copy
    assign sdi = (bitCnt_r == 3'h0 && sck) ? ~bit_r : bit_r;
    // next bit goes out on the falling edge, msb of the frame first
    always @(negedge sck or negedge resetn)
        if (!resetn)
        begin
            shift_r <= 8'h00;
            bit_r <= 1'b0;
        end
        else if (bitCnt_r == 3'h0)
        begin
            bit_r <= peerTx[7];
            shift_r <= {peerTx[6:0], 1'b0};
        end
        else
        begin
            bit_r <= shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
        end
    // every byte both sends and receives; frames are exactly eight bits
    always @(posedge sck or negedge resetn)
        if (!resetn)
        begin
            peerRx <= 8'h00;
            bitCnt_r <= 3'h0;
            peerFrames <= 0;
        end
        else
        begin
            peerRx <= {peerRx[6:0], sdo};
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7)
                peerFrames <= peerFrames + 1;
        end
endmodule // serial_peer_model
`default_nettype wire

// ---- serial_unit_a_chk.sv ----
// port-level checks on the serial unit, all sampled on clk_sys
// assumes binding into serial_unit_a; pins are watched from the system clock
`timescale 1ns/1ps
`default_nettype none
module serial_unit_a_chk
    import serial_unit_a_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic unitEnable,
    input wire logic autoTransferEnable,
    input wire logic receiveEnable,
    input wire logic transmitEnable,
    input wire logic [IDX_W-1:0] lastIndex,
    input wire logic autoStart,
    input wire logic shiftDataWrite,
    // status and pins
    input wire logic transferActive,
    input wire logic [IDX_W-1:0] byteIndex,
    input wire logic transferDoneIrq,
    input wire logic serialClockPin,
    input wire logic serialOutPin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_single_req;
        shiftDataWrite && unitEnable && !autoTransferEnable && !transferActive;
    endsequence
    sequence s_auto_req;
        autoStart && unitEnable && autoTransferEnable && (transmitEnable || receiveEnable)
            && !transferActive;
    endsequence
    // eight quiet cycles leave room for the pin domain to settle
    sequence s_quiet;
        !transferActive [*8];
    endsequence
    a_single_start: assert property (s_single_req |=> transferActive)
        else $error("single write did not start");
    a_auto_start: assert property (s_auto_req |=> transferActive && byteIndex == IDX_RST)
        else $error("auto start wrong");
    a_off_no_start: assert property (!unitEnable && !transferActive |=> !transferActive)
        else $error("started while disabled");
    a_irq_pulse: assert property (transferDoneIrq |=> !transferDoneIrq)
        else $error("done request longer than one cycle");
    a_irq_ends_run: assert property (transferDoneIrq |-> !transferActive && $past(transferActive))
        else $error("done request without end of run");
    a_enable_abort: assert property (!unitEnable [*2] |-> !transferActive && !transferDoneIrq)
        else $error("disable did not stop quietly");
    a_index_step: assert property (transferActive && $changed(byteIndex)
        |-> byteIndex == $past(byteIndex) + IDX_ONE || byteIndex == IDX_RST)
        else $error("index jumped");
    a_index_bound: assert property (transferActive |-> byteIndex <= lastIndex)
        else $error("index past last");
    a_idle_out_low: assert property (s_quiet |-> !serialOutPin)
        else $error("data pin high while idle");
    a_idle_clk_high: assert property (s_quiet |-> serialClockPin)
        else $error("clock pin low while idle");
endmodule // serial_unit_a_chk
bind serial_unit_a serial_unit_a_chk chk (.clk_sys, .resetn, .unitEnable, .autoTransferEnable,
    .receiveEnable, .transmitEnable, .lastIndex, .autoStart, .shiftDataWrite, .transferActive,
    .byteIndex, .transferDoneIrq, .serialClockPin, .serialOutPin);
`default_nettype wire

// ---- serial_unit_a_tb.sv ----
// self-checking bench: single bytes, automatic, transmit-only, repeat and abort
// assumes the peer model on the pins; clk_sys 25 ns, link clock 32 ns
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module serial_unit_a_tb
    import serial_unit_a_pkg::*;
;
    logic clk_sys = 0;
    logic clkLink = 0;
    logic resetn = 0;
    logic unitEnable = 0, autoTransferEnable = 0, repeatMode = 0, receiveEnable = 0;
    logic transmitEnable = 0, bitOrderSelect = 0, autoStart = 0, autoStop = 0;
    logic shiftDataWrite = 0, bufWrite = 0, bufRead = 0;
    // six link cycles per half bit: the input passes four flops before a rise takes it
    logic [DIV_W-1:0] clockDivisor = 8'h05;
    logic [BYTE_W-1:0] shiftDataIn = 8'h00, bufWriteData = 8'h00, peerTx = 8'h00;
    logic [BYTE_W-1:0] shiftDataOut, bufReadData, peerRx;
    logic [IDX_W-1:0] lastIndex = 5'h00, bufAddr = 5'h00, byteIndex;
    logic [GAP_W-1:0] interval = 6'h01;
    logic transferActive, transferDoneIrq, serialClockPin, serialOutPin, serialInPin;
    int n_mismatch = 0, compares = 0, cycles = 0, irqCount = 0, peerFrames, n, f;
    always #12.5 clk_sys = ~clk_sys;
    always #16 clkLink = ~clkLink;
    serial_unit_a uut (.clk_sys, .clkLink, .resetn, .unitEnable, .autoTransferEnable,
        .repeatMode, .receiveEnable, .transmitEnable, .bitOrderSelect, .clockDivisor,
        .lastIndex, .interval, .autoStart, .autoStop, .shiftDataWrite, .shiftDataIn,
        .shiftDataOut, .bufWrite, .bufRead, .bufAddr, .bufWriteData, .bufReadData,
        .transferActive, .byteIndex, .transferDoneIrq, .serialClockPin, .serialOutPin,
        .serialInPin);
    serial_peer_model peer (.resetn, .sck(serialClockPin), .sdo(serialOutPin),
        .sdi(serialInPin), .peerTx, .peerRx, .peerFrames);
    // counted on the falling edge so the pulse is read once settled
    always @(negedge clk_sys)
        if (transferDoneIrq === 1'b1)
            irqCount++;
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test;
        end
    end
    task automatic waitIrq(input int target);
        int k;
        k = 0;
        while (irqCount < target && k < 4000)
        begin
            @(posedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        `CHK(irqCount, target)
    endtask
    task automatic bufWr(input logic [IDX_W-1:0] a, input logic [BYTE_W-1:0] d);
        @(posedge clk_sys);
        bufWrite <= 1'b1;
        bufAddr <= a;
        bufWriteData <= d;
        @(posedge clk_sys);
        bufWrite <= 1'b0;
    endtask
    task automatic bufChk(input logic [IDX_W-1:0] a, input logic [BYTE_W-1:0] d);
        @(posedge clk_sys);
        bufRead <= 1'b1;
        bufAddr <= a;
        @(posedge clk_sys);
        bufRead <= 1'b0;
        @(negedge clk_sys);
        `CHK(bufReadData, d)
    endtask
    // interval only ever changes here, while the unit is idle
    task automatic runAuto(input logic rep, rx, tx, input logic [4:0] last, input logic [5:0] gap);
        @(posedge clk_sys);
        autoTransferEnable <= 1'b1;
        repeatMode <= rep;
        receiveEnable <= rx;
        transmitEnable <= tx;
        lastIndex <= last;
        interval <= gap;
        n = irqCount;
        f = peerFrames;
        @(posedge clk_sys);
        autoStart <= 1'b1;
        @(posedge clk_sys);
        autoStart <= 1'b0;
    endtask
    task automatic t_refuse;
        @(posedge clk_sys);
        unitEnable <= 1'b0;
        shiftDataWrite <= 1'b1;
        @(posedge clk_sys);
        shiftDataWrite <= 1'b0;
        unitEnable <= 1'b1;
        repeat (150) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(transferActive, 1'b0)
        `CHK(irqCount, 0)
    endtask
    // the repeat bit is set on purpose: it must change nothing here
    task automatic t_single(input logic lsb, input logic [7:0] d, pinOut, pinIn, got);
        @(posedge clk_sys);
        autoTransferEnable <= 1'b0;
        repeatMode <= 1'b1;
        bitOrderSelect <= lsb;
        peerTx <= pinIn;
        @(posedge clk_sys);
        shiftDataIn <= d;
        shiftDataWrite <= 1'b1;
        n = irqCount;
        @(posedge clk_sys);
        shiftDataWrite <= 1'b0;
        waitIrq(n + 1);
        `CHK(transferActive, 1'b0)
        `CHK(peerRx, pinOut)
        `CHK(shiftDataOut, got)
        `CHK(serialOutPin, 1'b0)
        `CHK(serialClockPin, 1'b1)
    endtask
    task automatic t_auto;
        for (int i = 0; i < 3; i++)
            bufWr(i[4:0], 8'(8'h11 * (i + 1)));
        peerTx <= 8'hC5;
        bitOrderSelect <= 1'b0;
        runAuto(1'b0, 1'b1, 1'b1, 5'h02, 6'h01);
        waitIrq(n + 1);
        `CHK(byteIndex, 5'h02)
        `CHK(peerFrames - f, 3)
        `CHK(peerRx, 8'h33)
        `CHK(transferActive, 1'b0)
        for (int i = 0; i < 3; i++)
            bufChk(i[4:0], 8'hC5);
    endtask
    task automatic t_txonly;
        bufWr(5'h00, 8'h5A);
        bufWr(5'h01, 8'h6B);
        runAuto(1'b0, 1'b0, 1'b1, 5'h01, 6'h00);
        waitIrq(n + 1);
        `CHK(peerRx, 8'h6B)
        `CHK(peerFrames - f, 2)
        bufChk(5'h00, 8'h5A);
        bufChk(5'h01, 8'h6B);
    endtask
    task automatic t_repeat;
        int k;
        runAuto(1'b1, 1'b0, 1'b1, 5'h01, 6'h02);
        k = 0;
        while (peerFrames - f < 3 && k < 4000)
        begin
            @(posedge clk_sys);
            k++;
        end
        `CHK(irqCount, n)
        @(posedge clk_sys);
        autoStop <= 1'b1;
        @(posedge clk_sys);
        autoStop <= 1'b0;
        waitIrq(n + 1);
        `CHK(transferActive, 1'b0)
    endtask
    task automatic t_abort;
        runAuto(1'b0, 1'b1, 1'b1, 5'h04, 6'h01);
        repeat (60) @(posedge clk_sys);
        unitEnable <= 1'b0;
        repeat (300) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(irqCount, n)
        `CHK(transferActive, 1'b0)
        `CHK(serialOutPin, 1'b0)
        `CHK(byteIndex, 5'h00)
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        unitEnable <= 1'b1;
        t_refuse;
        t_single(1'b0, 8'hA1, 8'hA1, 8'h36, 8'h36);
        t_single(1'b1, 8'hA1, 8'h85, 8'h36, 8'h6C);
        t_auto;
        t_txonly;
        t_repeat;
        t_abort;
        stop_test;
    end
endmodule // serial_unit_a_tb
`default_nettype wire
